// file: rtl/single_wire_slave_timing.sv
/*
 * Slave-side timing engine of an open-drain single-wire bus: reset and
 * presence, read and write slots, edge hold-off and the self-timed
 * conversion and programming intervals.
 * Assumes line_in is already synchronous to core_clk and that the command
 * layer pulses convert_req or copy_req at the last slot's rising edge.
 */
`timescale 1ns/100ps
`default_nettype none
`include "swire_consts.svh"

// Functional notes
// - After reset low ends, wait, then drive presence low for the set time.
// - Device holds its read bit until after the master's latest sample.
// - No falling edge is recognised until the hold-off after a rise.
// - Conversion finishes within the time set by the resolution.
// - Conversion starts one maximum hold-off after the command's last slot.
// - Programming starts one maximum hold-off after the copy command's last slot.
// - Programming finishes within ten milliseconds, then the device idles.
module single_wire_slave_timing #(
    parameter int TW = 25,
    parameter int RESET_DETECT_STD = `CYC_MIN(`RESET_DETECT_STD_NS),
    parameter int CONV_12BIT_CYCLES = `CYC_MAX(`CONV_12BIT_NS),
    parameter int PROG_CYCLES = `CYC_MAX(`PROG_MAX_NS)
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic line_in,
    output logic line_out,
    output logic line_oe,
    input wire logic overdrive,
    input wire logic read_bit_req,
    input wire logic tx_bit,
    output logic rx_bit,
    output logic rx_valid,
    output logic bus_reset,
    input wire logic convert_req,
    input wire logic copy_req,
    input wire logic [1:0] resolution,
    output logic conv_busy,
    output logic prog_busy,
    output logic conv_done,
    output logic prog_done,
    input wire logic chain_input_pin,
    output logic chain_level
);

    // ------------------------------------------------------------
    // Timing selection
    // ------------------------------------------------------------
    localparam logic [12:0] CNT_MAX = 13'h1FFF;
    localparam logic [7:0] HOLDOFF_MAX = 8'(`CYC_MIN(`EDGE_HOLDOFF_MAX_NS));

    swire_pkg::engine_state_t s;
    swire_pkg::engine_state_t next_s;
    ival_timer_if #(.W(TW)) tif ();

    logic [12:0] t_sample;
    logic [12:0] t_rdhold;
    logic [12:0] t_rstdet;
    logic [12:0] t_pwait;
    logic [12:0] t_plow;
    logic [12:0] t_hold;
    logic [TW-1:0] conv_cycles;

    assign t_sample = s.od ? 13'(`CYC_MIN(`WRITE_SAMPLE_OD_NS)) :
        13'(`CYC_MIN(`WRITE_SAMPLE_STD_NS));
    assign t_rdhold = s.od ? 13'(`CYC_MIN(`READ_HOLD_OD_NS)) :
        13'(`CYC_MIN(`READ_HOLD_STD_NS));
    assign t_rstdet = s.od ? 13'(`CYC_MIN(`RESET_DETECT_OD_NS)) : 13'(RESET_DETECT_STD);
    assign t_pwait = s.od ? 13'(`CYC_MIN(`PRES_WAIT_OD_NS)) :
        13'(`CYC_MIN(`PRES_WAIT_STD_NS));
    assign t_plow = s.od ? 13'(`CYC_MIN(`PRES_LOW_OD_NS)) : 13'(`CYC_MIN(`PRES_LOW_STD_NS));
    assign t_hold = s.od ? 13'(`CYC_MIN(`EDGE_HOLDOFF_OD_NS)) :
        13'(`CYC_MIN(`EDGE_HOLDOFF_STD_NS));
    // Each resolution step halves the conversion time
    assign conv_cycles = TW'(CONV_12BIT_CYCLES) >> (2'h3 - s.res);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.rx_valid = 1'b0;
        next_s.bus_reset = 1'b0;
        next_s.conv_done = 1'b0;
        next_s.prog_done = 1'b0;
        next_s.chain_level = chain_input_pin;
        tif.load = 1'b0;
        tif.count = '0;
        unique case (s.slot)
            swire_pkg::S_IDLE:
                if (!line_in)
                begin
                    next_s.slot = swire_pkg::S_LOW;
                    next_s.cnt = 13'h0001;
                    next_s.od = overdrive;
                    next_s.drive = read_bit_req && !tx_bit;
                end
            swire_pkg::S_LOW:
            begin
                if (s.cnt != CNT_MAX)
                    next_s.cnt = s.cnt + 13'h0001;
                if (s.cnt == t_sample)
                begin
                    next_s.rx_bit = line_in;
                    next_s.rx_valid = 1'b1;
                end
                if (s.cnt == t_rdhold)
                    next_s.drive = 1'b0;
                // While we pull low the line cannot read high
                // A rise before the sample point is a write one: keep timing until sampled
                if (line_in && !s.drive && s.cnt > t_sample)
                begin
                    next_s.cnt = 13'h0001;
                    if (s.cnt >= t_rstdet)
                    begin
                        next_s.slot = swire_pkg::S_PWAIT;
                        next_s.bus_reset = 1'b1;
                        next_s.od = overdrive;
                    end
                    else
                        next_s.slot = swire_pkg::S_HOLD;
                end
            end
            swire_pkg::S_PWAIT:
            begin
                next_s.cnt = s.cnt + 13'h0001;
                if (s.cnt == t_pwait)
                begin
                    next_s.slot = swire_pkg::S_PLOW;
                    next_s.cnt = 13'h0001;
                    next_s.drive = 1'b1;
                end
            end
            swire_pkg::S_PLOW:
            begin
                next_s.cnt = s.cnt + 13'h0001;
                if (s.cnt == t_plow)
                begin
                    next_s.slot = swire_pkg::S_RISE;
                    next_s.drive = 1'b0;
                end
            end
            swire_pkg::S_RISE:
                if (line_in)
                begin
                    next_s.slot = swire_pkg::S_HOLD;
                    next_s.cnt = 13'h0001;
                end
            swire_pkg::S_HOLD:
            begin
                next_s.cnt = s.cnt + 13'h0001;
                if (s.cnt >= t_hold)
                    next_s.slot = swire_pkg::S_IDLE;
            end
        endcase

        // Intervals run independently of slot timing
        unique case (s.ival)
            swire_pkg::I_IDLE:
                if (convert_req || copy_req)
                begin
                    next_s.ival = swire_pkg::I_DELAY;
                    next_s.dcnt = 8'h01;
                    next_s.is_copy = copy_req;
                    next_s.res = resolution;
                end
            swire_pkg::I_DELAY:
            begin
                next_s.dcnt = s.dcnt + 8'h01;
                if (s.dcnt == HOLDOFF_MAX)
                begin
                    tif.load = 1'b1;
                    if (s.is_copy)
                    begin
                        next_s.ival = swire_pkg::I_PROG;
                        tif.count = TW'(PROG_CYCLES);
                    end
                    else
                    begin
                        next_s.ival = swire_pkg::I_CONV;
                        tif.count = conv_cycles;
                    end
                end
            end
            swire_pkg::I_CONV:
                if (tif.expired)
                begin
                    next_s.ival = swire_pkg::I_IDLE;
                    next_s.conv_done = 1'b1;
                end
            swire_pkg::I_PROG:
                if (tif.expired)
                begin
                    next_s.ival = swire_pkg::I_IDLE;
                    next_s.prog_done = 1'b1;
                end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            s <= '0;
            s.slot <= swire_pkg::S_IDLE;
            s.ival <= swire_pkg::I_IDLE;
        end
        else
            s <= next_s;
    end

    ival_timer #(.W(TW)) u_timer (
        .core_clk(core_clk),
        .reset(reset),
        .tif(tif)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign line_out = 1'b0;
    assign line_oe = s.drive;
    assign rx_bit = s.rx_bit;
    assign rx_valid = s.rx_valid;
    assign bus_reset = s.bus_reset;
    assign conv_busy = (s.ival == swire_pkg::I_CONV);
    assign prog_busy = (s.ival == swire_pkg::I_PROG);
    assign conv_done = s.conv_done;
    assign prog_done = s.prog_done;
    assign chain_level = s.chain_level;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_presence_drive: assert property ((s.slot == swire_pkg::S_PLOW) |-> line_oe)
        else $error("presence low not driven");
    a_presence_length: assert property ($fell(line_oe) && $past(s.slot) == swire_pkg::S_PLOW
        |-> $past(s.cnt) == t_plow)
        else $error("presence low length wrong");
    a_presence_wait: assert property ((s.slot == swire_pkg::S_PWAIT)
        |-> !line_oe && s.cnt <= t_pwait)
        else $error("presence wait wrong");
    a_read_hold: assert property ($rose(line_oe) && $past(s.slot) == swire_pkg::S_IDLE
        |-> line_oe [*8])
        else $error("read bit released early");
    a_holdoff_edge: assert property ((s.slot == swire_pkg::S_HOLD)
        |=> s.slot != swire_pkg::S_LOW)
        else $error("falling edge taken in hold-off");
    a_speed_stable: assert property ($changed(s.od)
        |-> $past(s.slot) == swire_pkg::S_IDLE || $past(s.slot) == swire_pkg::S_LOW)
        else $error("speed changed inside a slot");
    a_conv_start: assert property ($rose(conv_busy)
        |-> $past(s.ival) == swire_pkg::I_DELAY && $past(s.dcnt) == HOLDOFF_MAX)
        else $error("conversion start not after hold-off");
    a_prog_start: assert property ($rose(prog_busy)
        |-> $past(s.ival) == swire_pkg::I_DELAY && $past(s.dcnt) == HOLDOFF_MAX)
        else $error("programming start not after hold-off");
    a_conv_end: assert property ($fell(conv_busy) |-> conv_done && !prog_busy)
        else $error("conversion ended without done");
    a_prog_end: assert property ($fell(prog_busy) |-> prog_done)
        else $error("programming ended without done");

endmodule // single_wire_slave_timing

`default_nettype wire

// file: include/swire_consts.svh
/*
 * Timing constants for the single-wire slave timing engine.
 * Assumes a 25 MHz core clock; all times are in nanoseconds.
 */
`ifndef SWIRE_CONSTS_SVH
`define SWIRE_CONSTS_SVH

`define CLK_PERIOD_NS 40
// Least times round up, longest times round down, never below one cycle
`define CYC_MIN(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
    (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define CYC_MAX(ns) ((((ns) / `CLK_PERIOD_NS) < 1) ? 1 : ((ns) / `CLK_PERIOD_NS))

// Presence pulse, inside the 15..60 us / 2..6 us and 60..240 us / 8..24 us windows
`define PRES_WAIT_STD_NS 30000
`define PRES_WAIT_OD_NS 3000
`define PRES_LOW_STD_NS 120000
`define PRES_LOW_OD_NS 12000
// Line low this long is a bus reset, not a slot
`define RESET_DETECT_STD_NS 300000
`define RESET_DETECT_OD_NS 40000
// Write sample point, between longest write-one and shortest write-zero low
`define WRITE_SAMPLE_STD_NS 30000
`define WRITE_SAMPLE_OD_NS 3000
// Read zero held past the latest master sample point
`define READ_HOLD_STD_NS 30000
`define READ_HOLD_OD_NS 3000
// Rising-edge hold-off
`define EDGE_HOLDOFF_STD_NS 500
`define EDGE_HOLDOFF_OD_NS 0
`define EDGE_HOLDOFF_MAX_NS 5000
// Self-timed intervals
`define CONV_12BIT_NS 750000000
`define PROG_MAX_NS 10000000

`endif

// file: include/swire_pkg.sv
/*
 * Types for the single-wire slave timing engine.
 * Assumes nothing beyond the constants header.
 */
package swire_pkg;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_LOW = 6'h02,
        S_PWAIT = 6'h04,
        S_PLOW = 6'h08,
        S_RISE = 6'h10,
        S_HOLD = 6'h20
    } slot_state_t;

    typedef enum logic [3:0] {
        I_IDLE = 4'h1,
        I_DELAY = 4'h2,
        I_CONV = 4'h4,
        I_PROG = 4'h8
    } ival_state_t;

    typedef struct packed {
        slot_state_t slot;
        logic [12:0] cnt;
        logic od;
        logic drive;
        logic rx_bit;
        logic rx_valid;
        logic bus_reset;
        ival_state_t ival;
        logic [7:0] dcnt;
        logic is_copy;
        logic [1:0] res;
        logic conv_done;
        logic prog_done;
        logic chain_level;
    } engine_state_t;

endpackage

// file: include/ival_timer_if.sv
/*
 * Carrier between the engine and its interval timer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface ival_timer_if #(parameter int W = 25);
    logic load;
    logic [W-1:0] count;
    logic expired;
    modport ctrl (output load, output count, input expired);
    modport tmr (input load, input count, output expired);
endinterface

`default_nettype wire

// file: rtl/ival_timer.sv
/*
 * Down counter for the long self-timed intervals.
 * Assumes load is a one-cycle pulse with a nonzero count.
 */
`timescale 1ns/100ps
`default_nettype none

module ival_timer #(
    parameter int W = 25
) (
    input wire logic core_clk,
    input wire logic reset,
    ival_timer_if.tmr tif
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic run;
        logic expired;
    } timer_state_t;

    timer_state_t s;
    timer_state_t next_s;

    always_comb
    begin
        next_s = s;
        next_s.expired = 1'b0;
        if (tif.load)
        begin
            next_s.cnt = tif.count;
            next_s.run = 1'b1;
        end
        else if (s.run)
        begin
            next_s.cnt = s.cnt - 1'b1;
            if (s.cnt == W'(1))
            begin
                next_s.run = 1'b0;
                next_s.expired = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            s <= '0;
        else
            s <= next_s;
    end

    assign tif.expired = s.expired;

endmodule // ival_timer

`default_nettype wire

// file: verif/swire_master_model.sv
/*
 * Bus master model with pullup for the single-wire slave timing bench.
 * Assumes a 25 MHz core_clk; callers enter its tasks at a falling edge.
 */
`timescale 1ns/100ps
`default_nettype none

module swire_master_model (
    input wire logic core_clk,
    input wire logic dev_oe,
    output logic line
);
    // --------------------------------
    // Timings in cycles, index 1 = overdrive
    // --------------------------------
    // Reset low shortened, yet above the bench's reset detect and the longest write zero
    localparam int RST_LOW [2] = '{3500, 1500};
    localparam int PSMP [2] = '{1750, 213};
    localparam int PEND [2] = '{4000, 500};
    localparam int W0 [2] = '{2000, 250};
    localparam int W1 [2] = '{250, 38};
    localparam int RDL [2] = '{150, 25};
    localparam int RSMP [2] = '{325, 45};
    localparam int SLOT [2] = '{2200, 300};
    logic pull_low = 1'b0;
    // Bypass of the pullup; it only stiffens the high level, the logic level is unchanged
    logic strong_pullup = 1'b0;

    // Pullup wins whenever nobody pulls
    assign line = ~(pull_low | dev_oe);

    task automatic pulse(input int low, input int after);
        pull_low = 1'b1;
        repeat (low) @(negedge core_clk);
        pull_low = 1'b0;
        repeat (after) @(negedge core_clk);
    endtask

    task automatic bus_reset_cycle(input logic od, output logic seen, output int wc,
        output int lc);
        wc = 0;
        lc = 0;
        seen = 1'b0;
        pulse(RST_LOW[od], 0);
        for (int i = 1; i <= PEND[od]; i++)
        begin
            @(negedge core_clk);
            if (dev_oe === 1'b1) lc++;
            else if (lc == 0) wc++;
            if (i == PSMP[od]) seen = ~line;
        end
    endtask

    task automatic write_bit(input logic od, input logic b);
        pulse(b ? W1[od] : W0[od], SLOT[od] - (b ? W1[od] : W0[od]));
    endtask

    task automatic read_bit(input logic od, output logic b);
        pulse(RDL[od], RSMP[od] - RDL[od]);
        b = line;
        repeat (SLOT[od] - RSMP[od]) @(negedge core_clk);
    endtask
endmodule // swire_master_model

`default_nettype wire

// file: verif/tb_top.sv
/*
 * Self-checking bench for the single-wire slave timing engine.
 * Assumes the master model and shortened reset detect and interval counts.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    // --------------------------------
    // Signals, design and master
    // --------------------------------
    localparam int CONV_CYC = 64;
    localparam int PROG_CYC = 40;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    int rx_n = 0;
    int rst_n = 0;
    logic rx_last;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic line_in;
    logic line_oe;
    logic overdrive = 1'b0;
    logic read_bit_req = 1'b0;
    logic tx_bit = 1'b1;
    logic rx_bit;
    logic rx_valid;
    logic bus_reset;
    logic convert_req = 1'b0;
    logic copy_req = 1'b0;
    logic [1:0] resolution = 2'h0;
    logic conv_busy;
    logic prog_busy;
    logic conv_done;
    logic prog_done;
    logic chain_input_pin = 1'b0;
    logic chain_level;

    always #20 core_clk = ~core_clk;

    single_wire_slave_timing #(.RESET_DETECT_STD(3200), .CONV_12BIT_CYCLES(CONV_CYC),
        .PROG_CYCLES(PROG_CYC)) uut (.core_clk(core_clk), .reset(reset), .line_in(line_in),
        .line_out(), .line_oe(line_oe), .overdrive(overdrive), .read_bit_req(read_bit_req),
        .tx_bit(tx_bit), .rx_bit(rx_bit), .rx_valid(rx_valid), .bus_reset(bus_reset),
        .convert_req(convert_req), .copy_req(copy_req), .resolution(resolution),
        .conv_busy(conv_busy), .prog_busy(prog_busy), .conv_done(conv_done),
        .prog_done(prog_done), .chain_input_pin(chain_input_pin), .chain_level(chain_level));

    swire_master_model mst (.core_clk(core_clk), .dev_oe(line_oe), .line(line_in));

    // The rx_valid and bus_reset pulses are counted here so blocking slot tasks cannot miss them
    always @(posedge core_clk)
    begin
        cycles++;
        if (rx_valid === 1'b1) rx_n++;
        if (rx_valid === 1'b1) rx_last = rx_bit;
        if (bus_reset === 1'b1) rst_n++;
        if (cycles == 60000)
        begin
            err_count++;
            conclude();
        end
    end

    // --------------------------------
    // Checks and scenarios
    // --------------------------------
    task automatic conclude();
        if (err_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check_bit(input logic act, input logic exp, input string what);
        check_count++;
        if (act !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t %s", $time, what);
        end
    endtask

    task automatic check_range(input int v, input int lo, input int hi, input string what);
        check_count++;
        if (v < lo || v > hi)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t %s %0d", $time, what, v);
        end
    endtask

    task automatic presence(input logic od);
        logic seen;
        int w;
        int lo;
        int r0;
        r0 = rst_n;
        mst.bus_reset_cycle(od, seen, w, lo);
        check_bit(seen, 1'b1, "presence");
        check_range(w, od ? 50 : 375, od ? 150 : 1500, "presence wait");
        check_range(lo, od ? 200 : 1500, od ? 600 : 6000, "presence low");
        check_range(rst_n - r0, 1, 1, "reset pulse");
    endtask

    task automatic slots(input logic od);
        logic b;
        int r0;
        for (int i = 0; i < 2; i++)
        begin
            r0 = rx_n;
            read_bit_req = 1'b0;
            mst.write_bit(od, i[0]);
            check_range(rx_n - r0, 1, 1, "write count");
            check_bit(rx_last, i[0], "write bit");
            read_bit_req = 1'b1;
            tx_bit = i[0];
            mst.read_bit(od, b);
            check_bit(b, i[0], "read bit");
        end
        read_bit_req = 1'b0;
    endtask

    // Speed flips mid-slot; the read zero must keep the standard hold
    task automatic speed_hold();
        logic b;
        read_bit_req = 1'b1;
        tx_bit = 1'b0;
        fork
            mst.read_bit(1'b0, b);
            begin
                repeat (60) @(negedge core_clk);
                overdrive = 1'b1;
            end
        join
        overdrive = 1'b0;
        read_bit_req = 1'b0;
        check_bit(b, 1'b0, "speed held");
    endtask

    task automatic holdoff();
        int r0;
        r0 = rx_n;
        mst.pulse(2000, 4);
        mst.pulse(3, 1500);
        check_range(rx_n - r0, 1, 1, "holdoff count");
        check_bit(rx_last, 1'b0, "holdoff bit");
    endtask

    task automatic interval(input logic cp, input logic [1:0] res, input int len);
        int n;
        @(negedge core_clk);
        copy_req = cp;
        convert_req = 1'b1;
        resolution = res;
        @(negedge core_clk);
        copy_req = 1'b0;
        convert_req = 1'b0;
        n = 0;
        while ((cp ? prog_busy : conv_busy) !== 1'b1 && n < 300)
        begin
            @(negedge core_clk);
            n++;
        end
        check_range(n, 125, 125, "start");
        mst.strong_pullup = 1'b1;
        check_bit(cp ? conv_busy : prog_busy, 1'b0, "other busy");
        n = 0;
        while ((cp ? prog_busy : conv_busy) === 1'b1 && n < 200)
        begin
            convert_req = (n == 5);
            @(negedge core_clk);
            n++;
        end
        mst.strong_pullup = 1'b0;
        check_range(n, len, len, "length");
        check_bit(cp ? prog_done : conv_done, 1'b1, "done");
        convert_req = 1'b0;
        repeat (150) @(negedge core_clk);
        check_bit(conv_busy | prog_busy, 1'b0, "late start");
    endtask

    task automatic chain();
        for (int i = 0; i < 2; i++)
        begin
            @(negedge core_clk);
            chain_input_pin = ~i[0];
            @(negedge core_clk);
            check_bit(chain_level, ~i[0], "chain level");
        end
    endtask

    initial
    begin
        repeat (6) @(negedge core_clk);
        reset = 1'b0;
        check_bit(line_oe, 1'b0, "idle oe");
        check_bit(conv_busy | prog_busy, 1'b0, "idle busy");
        @(negedge core_clk);
        presence(1'b0);
        slots(1'b0);
        speed_hold();
        holdoff();
        overdrive = 1'b1;
        presence(1'b1);
        slots(1'b1);
        overdrive = 1'b0;
        presence(1'b0);
        for (int r = 0; r < 4; r++) interval(1'b0, r[1:0], (CONV_CYC >> (3 - r)) + 1);
        interval(1'b1, 2'h0, PROG_CYC + 1);
        chain();
        conclude();
    end
endmodule // tb_top

`default_nettype wire
